//--- jtag_pod_model.sv
`timescale 1ns/1ps

// =====
// Scan pod, tck idles low between frames
module jtag_pod_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_o,
    input wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        trst_o = 1'b0;
    end

    task automatic step(input logic m, input logic d, output logic o);
        tms_o = m;
        tdi_o = d;
        #24 tck_o = 1'b1;
        o = tdo_i;
        #24 tck_o = 1'b0;
    endtask

    task automatic set_trst(input logic v);
        logic b;
        trst_o = v;
        #100;
        if (v) begin
            repeat (5) step(1'b1, 1'b1, b);
            step(1'b0, 1'b1, b);
        end
    endtask

    task automatic scan(input logic ir, input logic [31:0] din, input int n,
            output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b1, b);
        if (ir) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule // jtag_pod_model

//--- jtag_port_pkg.sv
package jtag_port_pkg;

    // ==========================================================
    // Instruction register
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
    localparam logic [IR_W-1:0] IR_DATA = 4'h2;
    localparam logic [IR_W-1:0] IR_EMU_CFG = 4'h3;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;

    // ==========================================================
    // Data registers
    localparam int DR_MAX_W = 32;
    localparam int IDCODE_W = 32;
    localparam int EMU_CFG_W = 2;
    localparam int BYPASS_W = 1;
    localparam int STATUS_PENDING_BIT = 0;
    // Identification value is arbitrary; bit 0 set as the standard asks
    localparam logic [IDCODE_W-1:0] IDCODE_DEFAULT = 32'h0000_0a51;

    // ==========================================================
    // Tap controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_e;

    // ==========================================================
    // Emulator pin direction, one bit per pin, 1 = device drives
    typedef struct packed {
        logic drive_b;
        logic drive_a;
    } emu_cfg_s;

    localparam emu_cfg_s EMU_CFG_RESET = emu_cfg_s'(2'h0);

endpackage

//--- jtag_tap_checker_assertions.sv
`timescale 1ns/1ps

// =====
// Port checks
module jtag_tap_checker #(
    parameter int DATA_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic trst_i,
    input wire logic tdo_oe_n_o,
    input wire logic emulator_pin_a_i,
    input wire logic emulator_pin_b_i,
    input wire logic emulator_pin_a_oe_n_o,
    input wire logic emulator_pin_b_oe_n_o,
    input wire logic emulator_irq_a_o,
    input wire logic emulator_irq_b_o,
    input wire logic scan_control_o,
    input wire logic boundary_scan_o,
    input wire logic word_valid_o,
    input wire logic [DATA_W-1:0] word_data_o,
    input wire logic word_ready_i
);
    sequence s_bscan_arm;
        $rose(trst_i) && emulator_pin_a_i && !emulator_pin_b_i;
    endsequence

    a_scan_on_trst: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(trst_i) |-> ##[1:4] scan_control_o)
        else $error("scan control late");
    a_func_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !trst_i [*4] |-> !scan_control_o && tdo_oe_n_o)
        else $error("scan active with test reset low");
    a_pins_released: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !trst_i [*5] |-> emulator_pin_a_oe_n_o && emulator_pin_b_oe_n_o)
        else $error("pin driven with test reset low");
    a_irq_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !trst_i [*5] |-> !emulator_irq_a_o && !emulator_irq_b_o)
        else $error("irq seen with test reset low");
    a_bscan_latch: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s_bscan_arm |-> ##[1:5] boundary_scan_o)
        else $error("boundary scan not latched");
    a_bscan_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        boundary_scan_o |=> boundary_scan_o)
        else $error("boundary scan dropped");
    a_word_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_data_o))
        else $error("word changed before pop");
    a_oe_leave_shift: assert property (
        @(posedge tck_i) disable iff (!trst_i)
        $past(!tdo_oe_n_o) && tdo_oe_n_o |-> $past(tms_i))
        else $error("tdo released without exit");
    a_oe_enter_shift: assert property (
        @(posedge tck_i) disable iff (!trst_i)
        $past(tdo_oe_n_o) && !tdo_oe_n_o |-> !$past(tms_i))
        else $error("tdo driven without shift entry");
endmodule // jtag_tap_checker

bind jtag_test_access_port jtag_tap_checker #(.DATA_W(DATA_W)) chk_u (
    .clk_i, .rst_i, .tck_i, .tms_i, .trst_i, .tdo_oe_n_o,
    .emulator_pin_a_i, .emulator_pin_b_i, .emulator_pin_a_oe_n_o,
    .emulator_pin_b_oe_n_o, .emulator_irq_a_o, .emulator_irq_b_o,
    .scan_control_o, .boundary_scan_o, .word_valid_o, .word_data_o,
    .word_ready_i
);

//--- jtag_test_access_port.sv
`timescale 1ns/1ps

// ==========================================================
// Word FIFO, shift organised so the head is always entry 0
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    typedef struct packed {
        logic [DEPTH-1:0] vld;
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } fifo_state_s;

    fifo_state_s q, d;

    always_comb begin
        logic placed;
        placed = 1'b0;
        d = q;
        if (q.vld[0] && out_ready_i) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.mem[i] = q.mem[i+1];
                d.vld[i] = q.vld[i+1];
            end
            d.vld[DEPTH-1] = 1'b0;
        end
        if (in_valid_i && !q.vld[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!d.vld[i] && !placed) begin
                    d.mem[i] = in_data_i;
                    d.vld[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready_o = ~q.vld[DEPTH-1];
    assign out_valid_o = q.vld[0];
    assign out_data_o = q.mem[0];
endmodule // word_fifo

module jtag_test_access_port
    import jtag_port_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int FIFO_DEPTH = 8,
    parameter logic [IDCODE_W-1:0] IDCODE = IDCODE_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    input wire logic emulator_pin_a_i,
    output logic emulator_pin_a_o,
    output logic emulator_pin_a_oe_n_o,
    input wire logic emulator_pin_b_i,
    output logic emulator_pin_b_o,
    output logic emulator_pin_b_oe_n_o,
    input wire logic emulator_irq_a_i,
    input wire logic emulator_irq_b_i,
    output logic emulator_irq_a_o,
    output logic emulator_irq_b_o,
    output logic scan_control_o,
    output logic boundary_scan_o,
    output logic word_valid_o,
    output logic [DATA_W-1:0] word_data_o,
    input wire logic word_ready_i
);

    // ==========================================================
    // Test clock domain
    typedef struct packed {
        tap_state_e st;
        logic [IR_W-1:0] ir_sr;
        logic [IR_W-1:0] ir;
        logic [DR_MAX_W-1:0] dr_sr;
        emu_cfg_s cfg;
        logic [DATA_W-1:0] word;
        logic req;
        logic ack_m;
        logic ack_s;
    } tck_state_s;

    typedef struct packed {
        logic tdo;
        logic oe_n;
    } tdo_state_s;

    typedef struct packed {
        logic trst_m;
        logic trst_s;
        logic trst_prev;
        logic pa_m;
        logic pa_s;
        logic pb_m;
        logic pb_s;
        logic req_m;
        logic req_s;
        logic ack;
        emu_cfg_s cfg_m;
        emu_cfg_s cfg_s;
        logic bscan;
        logic irq_a;
        logic irq_b;
        logic pin_a;
        logic pin_b;
        logic oe_a_n;
        logic oe_b_n;
    } sys_state_s;

    tck_state_s t_q, t_d;
    tdo_state_s o_q, o_d;
    sys_state_s s_q, s_d;
    logic pending;
    int dr_len;
    logic fifo_in_ready;

    assign pending = t_q.req ^ t_q.ack_s;

    always_comb begin
        case (t_q.ir)
            IR_IDCODE: dr_len = IDCODE_W;
            IR_DATA: dr_len = DATA_W;
            IR_EMU_CFG: dr_len = EMU_CFG_W;
            default: dr_len = BYPASS_W;
        endcase
    end

    always_comb begin
        t_d = t_q;
        t_d.ack_m = s_q.ack;
        t_d.ack_s = t_q.ack_m;
        case (t_q.st)
            TEST_LOGIC_RESET: t_d.st = tms_i ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE: t_d.st = tms_i ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: t_d.st = tms_i ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: t_d.st = tms_i ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: t_d.st = tms_i ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: t_d.st = tms_i ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: t_d.st = tms_i ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: t_d.st = tms_i ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: t_d.st = tms_i ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: t_d.st = tms_i ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR: t_d.st = tms_i ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: t_d.st = tms_i ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: t_d.st = tms_i ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: t_d.st = tms_i ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: t_d.st = tms_i ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: t_d.st = tms_i ? SELECT_DR : RUN_TEST_IDLE;
            default: t_d.st = TEST_LOGIC_RESET;
        endcase
        case (t_q.st)
            TEST_LOGIC_RESET: begin
                t_d.ir = IR_IDCODE;
                t_d.cfg = EMU_CFG_RESET;
            end
            CAPTURE_IR: t_d.ir_sr = IR_CAPTURE_VAL;
            SHIFT_IR: t_d.ir_sr = {tdi_i, t_q.ir_sr[IR_W-1:1]};
            UPDATE_IR: t_d.ir = t_q.ir_sr;
            CAPTURE_DR: begin
                t_d.dr_sr = '0;
                case (t_q.ir)
                    IR_IDCODE: t_d.dr_sr[IDCODE_W-1:0] = IDCODE;
                    IR_DATA: t_d.dr_sr[STATUS_PENDING_BIT] = pending;
                    IR_EMU_CFG: t_d.dr_sr[EMU_CFG_W-1:0] = t_q.cfg;
                    default: t_d.dr_sr = '0;
                endcase
            end
            SHIFT_DR: begin
                t_d.dr_sr = {1'b0, t_q.dr_sr[DR_MAX_W-1:1]};
                t_d.dr_sr[dr_len-1] = tdi_i;
            end
            UPDATE_DR: begin
                if (t_q.ir == IR_DATA && !pending) begin
                    t_d.word = t_q.dr_sr[DATA_W-1:0];
                    t_d.req = ~t_q.req;
                end
                if (t_q.ir == IR_EMU_CFG) begin
                    t_d.cfg = emu_cfg_s'(t_q.dr_sr[EMU_CFG_W-1:0]);
                end
            end
            default: t_d.ir_sr = t_q.ir_sr;
        endcase
    end

    // Low test reset holds the whole scan side in reset
    always_ff @(posedge tck_i or negedge trst_i) begin
        if (!trst_i) begin
            t_q.st <= TEST_LOGIC_RESET;
            t_q.ir_sr <= '0;
            t_q.ir <= IR_IDCODE;
            t_q.dr_sr <= '0;
            t_q.cfg <= EMU_CFG_RESET;
            t_q.word <= '0;
            t_q.req <= 1'b0;
            t_q.ack_m <= 1'b0;
            t_q.ack_s <= 1'b0;
        end else begin
            t_q <= t_d;
        end
    end

    always_comb begin
        o_d.oe_n = ~(t_q.st == SHIFT_DR || t_q.st == SHIFT_IR);
        o_d.tdo = (t_q.st == SHIFT_IR) ? t_q.ir_sr[0] : t_q.dr_sr[0];
    end

    always_ff @(negedge tck_i or negedge trst_i) begin
        if (!trst_i) begin
            o_q.tdo <= 1'b0;
            o_q.oe_n <= 1'b1;
        end else begin
            o_q <= o_d;
        end
    end

    // ==========================================================
    // System clock domain
    always_comb begin
        logic active;
        active = s_q.trst_s;
        s_d = s_q;
        s_d.trst_m = trst_i;
        s_d.trst_s = s_q.trst_m;
        s_d.trst_prev = s_q.trst_s;
        s_d.pa_m = emulator_pin_a_i;
        s_d.pa_s = s_q.pa_m;
        s_d.pb_m = emulator_pin_b_i;
        s_d.pb_s = s_q.pb_m;
        s_d.req_m = t_q.req;
        s_d.req_s = s_q.req_m;
        s_d.cfg_m = t_q.cfg;
        s_d.cfg_s = s_q.cfg_m;
        // A scan reset drops the handshake without pushing a stale word
        if ((s_q.req_s != s_q.ack) && (fifo_in_ready || !active)) begin
            s_d.ack = s_q.req_s;
        end
        if (s_q.trst_s && !s_q.trst_prev && s_q.pa_s && !s_q.pb_s) begin
            s_d.bscan = 1'b1;
        end
        s_d.pin_a = emulator_irq_a_i;
        s_d.pin_b = emulator_irq_b_i;
        s_d.oe_a_n = ~(active && s_q.cfg_s.drive_a);
        s_d.oe_b_n = ~(active && s_q.cfg_s.drive_b);
        s_d.irq_a = active && !s_q.cfg_s.drive_a && s_q.pa_s;
        s_d.irq_b = active && !s_q.cfg_s.drive_b && s_q.pb_s;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.oe_a_n <= 1'b1;
            s_q.oe_b_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Scanned words into the system side
    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(s_q.trst_s && (s_q.req_s != s_q.ack)),
        .in_data_i(t_q.word),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(word_valid_o),
        .out_data_o(word_data_o),
        .out_ready_i(word_ready_i)
    );

    assign tdo_o = o_q.tdo;
    assign tdo_oe_n_o = o_q.oe_n;
    assign scan_control_o = s_q.trst_s;
    assign boundary_scan_o = s_q.bscan;
    assign emulator_pin_a_o = s_q.pin_a;
    assign emulator_pin_b_o = s_q.pin_b;
    assign emulator_pin_a_oe_n_o = s_q.oe_a_n;
    assign emulator_pin_b_oe_n_o = s_q.oe_b_n;
    assign emulator_irq_a_o = s_q.irq_a;
    assign emulator_irq_b_o = s_q.irq_b;

endmodule // jtag_test_access_port

//--- jtag_test_access_port_test.sv
`timescale 1ns/1ps

// =====
// Top bench
module jtag_test_access_port_test;
    import jtag_port_pkg::*;
    logic clk_i, rst_i, tck_i, tms_i, tdi_i, trst_i, tdo_o, tdo_oe_n_o;
    logic emulator_pin_a_i, emulator_pin_a_o, emulator_pin_a_oe_n_o;
    logic emulator_pin_b_i, emulator_pin_b_o, emulator_pin_b_oe_n_o;
    logic emulator_irq_a_i, emulator_irq_b_i, emulator_irq_a_o;
    logic emulator_irq_b_o, scan_control_o, boundary_scan_o;
    logic word_valid_o, word_ready_i, emu_drive_a, emu_drive_b;
    logic [15:0] word_data_o;
    logic [31:0] got;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    // Pin level: device when enabled, else emulator or pull-up
    assign emulator_pin_a_i = emulator_pin_a_oe_n_o ? emu_drive_a
                                                    : emulator_pin_a_o;
    assign emulator_pin_b_i = emulator_pin_b_oe_n_o ? emu_drive_b
                                                    : emulator_pin_b_o;

    // A released tdo reads as the inverse of the current tdo_o level
    logic tdo_seen;
    assign tdo_seen = tdo_oe_n_o ? ~tdo_o : tdo_o;

    jtag_test_access_port #(.DATA_W(16), .FIFO_DEPTH(8)) dut_u (
        .clk_i, .rst_i, .tck_i, .tms_i, .tdi_i, .trst_i, .tdo_o, .tdo_oe_n_o,
        .emulator_pin_a_i, .emulator_pin_a_o, .emulator_pin_a_oe_n_o,
        .emulator_pin_b_i, .emulator_pin_b_o, .emulator_pin_b_oe_n_o,
        .emulator_irq_a_i, .emulator_irq_b_i, .emulator_irq_a_o,
        .emulator_irq_b_o, .scan_control_o, .boundary_scan_o,
        .word_valid_o, .word_data_o, .word_ready_i);

    jtag_pod_model pod_u (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
        .trst_o(trst_i), .tdo_i(tdo_seen));

    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic t_idcode();
        settle(0);
        pod_u.set_trst(1'b1);
        pod_u.scan(1'b1, IR_IDCODE, IR_W, got);
        check("ir capture", IR_CAPTURE_VAL, got);
        pod_u.scan(1'b0, 32'h0, IDCODE_W, got);
        check("idcode", IDCODE_DEFAULT, got);
        settle(2);
        check("scan control", 1'b1, scan_control_o);
        $display("test idcode done");
    endtask

    task automatic t_words();
        int n;
        pod_u.scan(1'b1, IR_DATA, IR_W, got);
        for (int i = 0; i < 9; i++) pod_u.scan(1'b0, 32'ha5c0 + i, 16, got);
        pod_u.scan(1'b0, 32'hffff, 16, got);
        check("pending flag", 32'h1, got);
        settle(4);
        check("full valid", 1'b1, word_valid_o);
        for (int i = 0; i < 9; i++) begin
            n = 0;
            while (word_valid_o !== 1'b1 && n < 40) begin
                settle(0);
                n++;
            end
            check("word", 32'ha5c0 + i, word_data_o);
            @(posedge clk_i) word_ready_i <= 1'b1;
            @(posedge clk_i) word_ready_i <= 1'b0;
            @(negedge clk_i);
        end
        settle(4);
        check("drained", 1'b0, word_valid_o);
        $display("test words done");
    endtask

    task automatic t_emu();
        pod_u.scan(1'b1, IR_EMU_CFG, IR_W, got);
        pod_u.scan(1'b0, 32'h1, EMU_CFG_W, got);
        @(posedge clk_i) emulator_irq_a_i <= 1'b1;
        emu_drive_b <= 1'b0;
        settle(6);
        check("pin a oe_n", 1'b0, emulator_pin_a_oe_n_o);
        check("pin b oe_n", 1'b1, emulator_pin_b_oe_n_o);
        check("pin a level", 1'b1, emulator_pin_a_i);
        check("irq b low", 1'b0, emulator_irq_b_o);
        @(posedge clk_i) emu_drive_b <= 1'b1;
        settle(6);
        check("irq b high", 1'b1, emulator_irq_b_o);
        pod_u.scan(1'b0, 32'h2, EMU_CFG_W, got);
        settle(6);
        check("pin a oe_n", 1'b1, emulator_pin_a_oe_n_o);
        check("pin b oe_n", 1'b0, emulator_pin_b_oe_n_o);
        check("irq a high", 1'b1, emulator_irq_a_o);
        check("pin b level", 1'b0, emulator_pin_b_i);
        @(posedge clk_i) emulator_irq_b_i <= 1'b1;
        settle(2);
        check("pin b level", 1'b1, emulator_pin_b_i);
        $display("test emulator pins done");
    endtask

    task automatic t_bscan();
        @(posedge clk_i) emu_drive_b <= 1'b0;
        settle(0);
        pod_u.set_trst(1'b0);
        pod_u.scan(1'b1, IR_IDCODE, IR_W, got);
        check("ignored scan", 32'hf, got);
        settle(6);
        check("scan control", 1'b0, scan_control_o);
        check("tdo oe_n", 1'b1, tdo_oe_n_o);
        check("irq a", 1'b0, emulator_irq_a_o);
        check("boundary scan", 1'b0, boundary_scan_o);
        check("no stray word", 1'b0, word_valid_o);
        pod_u.set_trst(1'b1);
        settle(2);
        check("boundary scan", 1'b1, boundary_scan_o);
        $display("test boundary scan done");
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        rst_i = 1'b1;
        word_ready_i = 1'b0;
        emulator_irq_a_i = 1'b0;
        emulator_irq_b_i = 1'b0;
        emu_drive_a = 1'b1;
        emu_drive_b = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_idcode();
        t_words();
        t_emu();
        t_bscan();
        end_sim();
    end
endmodule // jtag_test_access_port_test
